// ==== include/fbrp_pkg.sv ====
// Constants and types of the flash burst read port
`default_nettype none
package fbrp_pkg;
    localparam int unsigned AW = 23;
    localparam int unsigned DW = 16;
    localparam int unsigned RAW = 4;
    localparam int unsigned CFG_W = 10;
    // Register offsets
    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_BANK = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    // Burst modes
    localparam logic [1:0] MODE_CONT = 2'h0;
    localparam logic [1:0] MODE_W8 = 2'h1;
    localparam logic [1:0] MODE_W16 = 2'h2;
    localparam logic [1:0] MODE_W32 = 2'h3;
    // Values after reset
    localparam logic [9:0] CFG_RST = 10'h002;
    localparam logic [3:0] BUSY_RST = 4'h0;
    localparam logic [5:0] PINS_RST = 6'h1F;
    // Bank starts, in words
    localparam logic [22:0] BANK1_START = 23'h08_0000;
    localparam logic [22:0] BANK2_START = 23'h20_0000;
    localparam logic [22:0] BANK3_START = 23'h38_0000;
    // Word positions and counts
    localparam logic [5:0] BOUND_LAST = 6'h3F;
    localparam logic [4:0] BOUND_PAIR = 5'h1F;
    localparam logic [5:0] BOUND_GAP = 6'h02;
    localparam logic [5:0] SLOW_GAP = 6'h01;
    localparam logic [5:0] REDUCED_EXTRA = 6'h02;
    localparam logic [5:0] ODD_EXTRA = 6'h01;
    localparam logic [7:0] WRAP_MAX = 8'h80;
    // Status word returned from a busy bank
    localparam logic [15:0] STATUS_WORD = 16'h0080;
    // Slow burst clock threshold
    localparam int unsigned CORE_FREQ_KHZ = 250000;
    localparam int unsigned SLOW_FREQ_KHZ = 6000;
    localparam logic [7:0] SLOW_CYC =
        8'(CORE_FREQ_KHZ / SLOW_FREQ_KHZ);

    typedef enum logic [2:0] {
        FBRP_ASYNC = 3'b000,
        FBRP_SIDLE = 3'b001,
        FBRP_WAIT = 3'b010,
        FBRP_RUN = 3'b011,
        FBRP_GAP = 3'b100,
        FBRP_HALT = 3'b101
    } fbrp_state_e;

    typedef struct packed {
        logic burst_clk;
        logic avd_n;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic clr_n;
    } fbrp_pins_s;

    typedef struct packed {
        logic reduced;
        logic sync_en;
        logic rdy_early;
        logic fall_edge;
        logic [1:0] mode;
        logic [3:0] waits;
    } fbrp_cfg_s;

    typedef struct packed {
        fbrp_state_e state;
        fbrp_pins_s pin_s1;
        fbrp_pins_s pin_s2;
        logic [22:0] adr_s1;
        logic [22:0] adr_s2;
        logic clk_prev;
        logic avd_prev;
        logic [22:0] addr;
        logic [5:0] cnt;
        logic [7:0] words;
        logic [7:0] period;
        logic slow;
        logic skip;
        fbrp_cfg_s cfg;
        logic [3:0] busy;
        logic [15:0] dout;
        logic doe;
        logic rdy;
        logic rdy_oe;
        logic [31:0] rdata;
    } fbrp_st_s;
endpackage
`default_nettype wire

// ==== core/fbrp_core.sv ====
// Flash burst read port: async read, burst engine and config registers
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Async read latches address on address_valid_n rise
// - Reset or hardware clear starts asynchronous mode
// - After configuration, reads are burst only
// - Config holds waits, mode, edge, ready, sync
// - First word after waits, then advance per edge
// - Continuous: two low-ready cycles past 64-word boundary
// - Standard variant: start 3E/3F skips next gap
// - Reduced variant: 3E/3F adds two initial cycles
// - Wraps to zero; ends on CE, clear, AVD
// - Idle bank crossing inserts same two cycles
// - Busy bank crossing returns status, ignores clock
// - Slow clock adds latency with ready low
// - Wrap modes stay inside aligned group
// - Wrap modes add mid-burst wait states only on a slow clock
// - Wrap output limited to 128 words
// - Output enable high suspends, state kept
// - Output enable low resumes at next edge
// - Ready driven whenever chip enable low
// - Reduced variant: ready rise marks first word
// - Standard variant: odd start adds one cycle
// - Rising clock edge is default active edge
// - Ready high when data valid, or one burst clock early with rdy_early set, else low
////////////////////////////////////////////////////////////////////////
module fbrp_core (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire fbrp_pkg::fbrp_pins_s i_pins,
    input wire logic [22:0] i_address_lines,
    output logic [22:0] o_array_addr,
    input wire logic [15:0] i_array_data,
    output logic [15:0] o_data_lines,
    output logic o_data_lines_oe,
    output logic o_word_valid_flag,
    output logic o_word_valid_oe,
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata
);
    fbrp_pkg::fbrp_st_s st;
    fbrp_pkg::fbrp_st_s next_st;
    fbrp_pkg::fbrp_pins_s ps;
    logic [22:0] ps_addr;
    logic act;
    logic avd_lo;
    logic avd_rise;
    logic ce_lo;
    logic oe_lo;
    logic live;
    logic go;
    logic cont;
    logic cross_lo;
    logic start_pair;
    logic [22:0] nxt;
    logic nxt_busy;
    logic [5:0] extra;

    ////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] bank_of(input logic [22:0] a);
        logic [1:0] b;
        b = 2'd3;
        if (a < fbrp_pkg::BANK1_START) begin
            b = 2'd0;
        end else if (a < fbrp_pkg::BANK2_START) begin
            b = 2'd1;
        end else if (a < fbrp_pkg::BANK3_START) begin
            b = 2'd2;
        end
        return b;
    endfunction

    // Next burst address; wrap modes keep the group bits
    function automatic logic [22:0] next_addr(input logic [22:0] a,
                                              input logic [1:0] m);
        logic [22:0] k;
        logic [22:0] inc;
        case (m)
            fbrp_pkg::MODE_W8: k = 23'h00_0007;
            fbrp_pkg::MODE_W16: k = 23'h00_000F;
            fbrp_pkg::MODE_W32: k = 23'h00_001F;
            default: k = 23'h7F_FFFF;
        endcase
        inc = a + 23'h00_0001;
        return (a & ~k) | (inc & k);
    endfunction

    ////////////////////////////////////////////////////////////////////
    assign ps = st.pin_s2;
    assign ps_addr = st.adr_s2;
    // Active edge of the sampled burst clock
    assign act = st.cfg.fall_edge ?
                 (st.clk_prev & ~ps.burst_clk) :
                 (~st.clk_prev & ps.burst_clk);
    assign avd_lo = ~ps.avd_n;
    assign avd_rise = ~st.avd_prev & ps.avd_n;
    assign ce_lo = ~ps.ce_n;
    assign oe_lo = ~ps.oe_n;
    assign live = ps.clr_n;
    assign go = act & oe_lo & ~avd_lo & ce_lo & ps.we_n & live;
    assign cont = (st.cfg.mode == fbrp_pkg::MODE_CONT);
    assign nxt = next_addr(st.addr, st.cfg.mode);
    assign cross_lo = (st.addr[5:0] == fbrp_pkg::BOUND_LAST);
    assign nxt_busy = (bank_of(nxt) != bank_of(st.addr)) &&
                      st.busy[bank_of(nxt)];
    assign start_pair = (ps_addr[5:1] == fbrp_pkg::BOUND_PAIR);
    always_comb begin
        extra = 6'h00;
        if (st.cfg.reduced && start_pair) begin
            extra = fbrp_pkg::REDUCED_EXTRA;
        end else if (!st.cfg.reduced && ps_addr[0]) begin
            extra = fbrp_pkg::ODD_EXTRA;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.pin_s1 = i_pins;
        next_st.pin_s2 = st.pin_s1;
        next_st.adr_s1 = i_address_lines;
        next_st.adr_s2 = st.adr_s1;
        next_st.clk_prev = ps.burst_clk;
        next_st.avd_prev = ps.avd_n;
        next_st.rdata = 32'h0000_0000;
        // Burst clock period measure
        if (act) begin
            next_st.period = 8'h00;
            next_st.slow = st.period > fbrp_pkg::SLOW_CYC;
        end else if (st.period != 8'hFF) begin
            next_st.period = st.period + 8'h01;
        end
        // Register port
        if (i_reg_wr) begin
            case (i_reg_addr)
                fbrp_pkg::REG_CFG: begin
                    next_st.cfg = fbrp_pkg::fbrp_cfg_s'(
                        i_reg_wdata[fbrp_pkg::CFG_W-1:0]);
                end
                fbrp_pkg::REG_BANK: next_st.busy = i_reg_wdata[3:0];
                default: begin
                end
            endcase
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                fbrp_pkg::REG_CFG: begin
                    next_st.rdata = {22'h00_0000, st.cfg};
                end
                fbrp_pkg::REG_BANK: begin
                    next_st.rdata = {28'h000_0000, st.busy};
                end
                fbrp_pkg::REG_STAT: begin
                    next_st.rdata = {5'h00, st.addr, st.slow, st.state};
                end
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
        // Read engine
        case (st.state)
            fbrp_pkg::FBRP_ASYNC: begin
                if (st.cfg.sync_en) begin
                    next_st.state = fbrp_pkg::FBRP_SIDLE;
                end else if (avd_rise && ce_lo) begin
                    next_st.addr = ps_addr;
                end
            end
            fbrp_pkg::FBRP_WAIT: begin
                if (go) begin
                    if (st.cnt == 6'h00) begin
                        next_st.state = fbrp_pkg::FBRP_RUN;
                        next_st.words = 8'h01;
                    end else begin
                        next_st.cnt = st.cnt - 6'h01;
                    end
                end
            end
            fbrp_pkg::FBRP_RUN: begin
                if (go) begin
                    if (!cont && st.words == fbrp_pkg::WRAP_MAX) begin
                        next_st.state = fbrp_pkg::FBRP_SIDLE;
                    end else begin
                        next_st.addr = nxt;
                        next_st.words = st.words + 8'h01;
                        if (cont && cross_lo) begin
                            if (nxt_busy) begin
                                next_st.state = fbrp_pkg::FBRP_HALT;
                            end else if (st.skip) begin
                                next_st.skip = 1'b0;
                            end else begin
                                next_st.state = fbrp_pkg::FBRP_GAP;
                                next_st.cnt = fbrp_pkg::BOUND_GAP;
                            end
                        end else if (st.slow) begin
                            next_st.state = fbrp_pkg::FBRP_GAP;
                            next_st.cnt = fbrp_pkg::SLOW_GAP;
                        end
                    end
                end
            end
            fbrp_pkg::FBRP_GAP: begin
                if (go) begin
                    if (st.cnt <= 6'h01) begin
                        next_st.state = fbrp_pkg::FBRP_RUN;
                    end else begin
                        next_st.cnt = st.cnt - 6'h01;
                    end
                end
            end
            fbrp_pkg::FBRP_HALT: begin
            end
            fbrp_pkg::FBRP_SIDLE: begin
            end
            default: next_st.state = fbrp_pkg::FBRP_ASYNC;
        endcase
        // Burst start, or restart over a running burst
        if (st.state != fbrp_pkg::FBRP_ASYNC && st.cfg.sync_en &&
            act && avd_lo && ce_lo && ps.we_n) begin
            next_st.state = fbrp_pkg::FBRP_WAIT;
            next_st.addr = ps_addr;
            next_st.words = 8'h00;
            next_st.skip = start_pair;
            next_st.cnt = {2'b00, st.cfg.waits} + extra;
        end
        if (!ce_lo && st.state != fbrp_pkg::FBRP_ASYNC) begin
            next_st.state = fbrp_pkg::FBRP_SIDLE;
        end
        if (!live) begin
            next_st.state = fbrp_pkg::FBRP_ASYNC;
            next_st.cfg = fbrp_pkg::fbrp_cfg_s'(fbrp_pkg::CFG_RST);
            next_st.busy = fbrp_pkg::BUSY_RST;
        end
        // Outputs follow the next state
        if (next_st.state == fbrp_pkg::FBRP_HALT) begin
            next_st.dout = fbrp_pkg::STATUS_WORD;
        end else if (next_st.state == fbrp_pkg::FBRP_RUN ||
                     next_st.state == fbrp_pkg::FBRP_ASYNC) begin
            next_st.dout = i_array_data;
        end
        next_st.doe = ce_lo && oe_lo && ps.we_n &&
                      next_st.state != fbrp_pkg::FBRP_SIDLE &&
                      next_st.state != fbrp_pkg::FBRP_WAIT;
        next_st.rdy = next_st.state == fbrp_pkg::FBRP_RUN ||
                      next_st.state == fbrp_pkg::FBRP_ASYNC ||
                      (st.cfg.rdy_early &&
                       next_st.state == fbrp_pkg::FBRP_WAIT &&
                       next_st.cnt == 6'h00);
        next_st.rdy_oe = ce_lo;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            st <= '0;
            st.state <= fbrp_pkg::FBRP_ASYNC;
            // Idle pin levels, burst clock low: no false edge
            st.pin_s1 <= fbrp_pkg::PINS_RST;
            st.pin_s2 <= fbrp_pkg::PINS_RST;
            st.avd_prev <= 1'b1;
            st.cfg <= fbrp_pkg::fbrp_cfg_s'(fbrp_pkg::CFG_RST);
            st.busy <= fbrp_pkg::BUSY_RST;
        end else begin
            st <= next_st;
        end
    end

    assign o_array_addr = st.addr;
    assign o_data_lines = st.dout;
    assign o_data_lines_oe = st.doe;
    assign o_word_valid_flag = st.rdy;
    assign o_word_valid_oe = st.rdy_oe;
    assign o_reg_rdata = st.rdata;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    sequence s_bound;
        st.state == fbrp_pkg::FBRP_RUN && go && cont && cross_lo &&
        !nxt_busy;
    endsequence
    sequence s_latch_odd;
        st.state != fbrp_pkg::FBRP_ASYNC && st.cfg.sync_en && act &&
        avd_lo && ce_lo && ps.we_n && live && !st.cfg.reduced &&
        ps_addr[0] && !i_reg_wr;
    endsequence
    sequence s_hold;
        (st.state == fbrp_pkg::FBRP_RUN ||
         st.state == fbrp_pkg::FBRP_WAIT) && !oe_lo && !avd_lo &&
        ce_lo && live;
    endsequence

    reset_async_a: assert property (
        $past(i_reset) |-> st.state == fbrp_pkg::FBRP_ASYNC &&
                           !st.cfg.sync_en)
        else $error("not in async mode after reset");
    async_latch_a: assert property (
        st.state == fbrp_pkg::FBRP_ASYNC && !st.cfg.sync_en &&
        avd_rise && ce_lo && live |=> st.addr == $past(ps_addr))
        else $error("async address not latched");
    sync_only_a: assert property (
        st.cfg.sync_en && live |=> st.state != fbrp_pkg::FBRP_ASYNC)
        else $error("async read while configured for burst");
    first_word_a: assert property (
        st.state == fbrp_pkg::FBRP_WAIT && st.cnt == 6'h00 && go
        |=> st.state == fbrp_pkg::FBRP_RUN && st.rdy)
        else $error("first word not presented");
    bound_gap_a: assert property (
        s_bound ##0 !st.skip |=> st.state == fbrp_pkg::FBRP_GAP &&
        st.cnt == fbrp_pkg::BOUND_GAP && !st.rdy)
        else $error("boundary gap missing");
    skip_gap_a: assert property (
        s_bound ##0 st.skip |=> st.state == fbrp_pkg::FBRP_RUN &&
        !st.skip)
        else $error("boundary gap not skipped");
    odd_start_a: assert property (
        s_latch_odd |=> st.cnt == $past({2'b00, st.cfg.waits}) + 6'h01)
        else $error("odd start delay wrong");
    gap_low_a: assert property (
        st.state == fbrp_pkg::FBRP_GAP |-> !o_word_valid_flag)
        else $error("ready high during latency");
    wrap_group_a: assert property (
        st.state == fbrp_pkg::FBRP_RUN && go && !cont
        |=> st.addr[22:5] == $past(st.addr[22:5]))
        else $error("wrap left its group");
    wrap_limit_a: assert property (
        st.state == fbrp_pkg::FBRP_RUN && go && !cont &&
        st.words == fbrp_pkg::WRAP_MAX |=> st.state ==
        fbrp_pkg::FBRP_SIDLE)
        else $error("wrap ran past limit");
    suspend_hold_a: assert property (
        s_hold |=> $stable(st.addr) && $stable(st.state))
        else $error("suspended burst changed");
    halt_status_a: assert property (
        st.state == fbrp_pkg::FBRP_HALT |->
        o_data_lines == fbrp_pkg::STATUS_WORD)
        else $error("busy bank without status");
    ce_end_a: assert property (
        !ce_lo && live && st.state != fbrp_pkg::FBRP_ASYNC
        |=> st.state == fbrp_pkg::FBRP_SIDLE ##1 !o_data_lines_oe)
        else $error("burst not ended by chip enable");
    rdy_drive_a: assert property (
        ce_lo |=> o_word_valid_oe)
        else $error("ready not driven");
    first_data_a: assert property (
        st.state == fbrp_pkg::FBRP_WAIT && st.cnt == 6'h00 && go
        |=> o_data_lines == $past(i_array_data))
        else $error("first word data wrong");
    advance_a: assert property (
        st.state == fbrp_pkg::FBRP_RUN && go && cont
        |=> st.addr == $past(st.addr) + 23'h00_0001)
        else $error("burst address not advanced");
    wrap_nogap_a: assert property (
        st.state == fbrp_pkg::FBRP_RUN && go && !cont && !st.slow
        |=> st.state != fbrp_pkg::FBRP_GAP)
        else $error("wait state inside wrap burst");
    busy_halt_a: assert property (
        st.state == fbrp_pkg::FBRP_RUN && go && cont && cross_lo &&
        nxt_busy |=> st.state == fbrp_pkg::FBRP_HALT && !st.rdy)
        else $error("busy bank not halted");
    oe_release_a: assert property (
        !oe_lo |=> !o_data_lines_oe)
        else $error("data lines driven while suspended");
    clear_async_a: assert property (
        !live |=> st.state == fbrp_pkg::FBRP_ASYNC &&
        st.busy == fbrp_pkg::BUSY_RST)
        else $error("clear did not restart async mode");
endmodule
`default_nettype wire

// ==== sim/fbrp_host.sv ====
// Host controller model: drives address, strobes and burst clock
`timescale 1ns/1ps
`default_nettype none
module fbrp_host (
    input wire logic [15:0] i_data_lines,
    input wire logic i_data_lines_oe,
    input wire logic i_word_valid_flag,
    input wire logic i_word_valid_oe,
    output var fbrp_pkg::fbrp_pins_s o_pins,
    output var logic [22:0] o_address_lines
);
    logic [15:0] words[$];
    logic [15:0] rd;
    logic [15:0] last_data;
    logic go;
    int init_lows;
    int post_lows;
    int pin_bad;
    // Burst clock low, all strobes idle
    initial begin
        o_pins = 6'h1F;
        o_address_lines = 23'h7F_FFFF;
    end
    // New address and address-valid pulse for every burst
    task automatic burst(input logic [22:0] a, input int n, input int sus);
        words.delete();
        init_lows = 0;
        post_lows = 0;
        pin_bad = 0;
        go = 1'b0;
        #17 o_pins.ce_n = 1'b0;
        o_pins.avd_n = 1'b0;
        o_address_lines = a;
        #16 o_pins.burst_clk = 1'b1;
        #16 o_pins.burst_clk = 1'b0;
        o_pins.avd_n = 1'b1;
        o_pins.oe_n = 1'b0;
        o_address_lines = ~a;
        for (int i = 0; i < n; i++) begin
            #16;
            if (!i_word_valid_oe) begin
                pin_bad++;
            end
            // A word stays pending until read with output enable low
            if (go && !o_pins.oe_n) begin
                go = 1'b0;
                if (i_word_valid_flag) begin
                    words.push_back(i_data_lines);
                    if (!i_data_lines_oe) begin
                        pin_bad++;
                    end
                end else if (words.size() == 0) begin
                    init_lows++;
                end else begin
                    post_lows++;
                end
            end
            last_data = i_data_lines;
            go = go || !o_pins.oe_n;
            o_pins.burst_clk = 1'b1;
            #16 o_pins.burst_clk = 1'b0;
            // Short suspend, then resume on the next edge
            o_pins.oe_n = (i >= sus && i < sus + 3);
        end
        o_pins.ce_n = 1'b1;
        o_pins.oe_n = 1'b1;
        #16;
    endtask
    task automatic async_read(input logic [22:0] a);
        #17 o_pins.ce_n = 1'b0;
        o_pins.avd_n = 1'b0;
        o_pins.oe_n = 1'b0;
        o_address_lines = a;
        #16 o_pins.avd_n = 1'b1;
        // Address held past the latching edge
        #16 o_address_lines = ~a;
        #24 rd = i_data_lines;
        o_pins.ce_n = 1'b1;
        o_pins.oe_n = 1'b1;
        #16;
    endtask
    task automatic clear();
        #17 o_pins.clr_n = 1'b0;
        #40 o_pins.clr_n = 1'b1;
        #16;
    endtask
endmodule
`default_nettype wire

// ==== sim/fbrp_core_tb.sv ====
// Self-checking bench for the flash burst read port
`timescale 1ns/1ps
`default_nettype none
module fbrp_core_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    fbrp_pkg::fbrp_pins_s pins;
    logic [22:0] addr_lines;
    logic [22:0] array_addr;
    logic [15:0] array_data;
    logic [15:0] data_lines;
    logic data_oe;
    logic rdy;
    logic rdy_oe;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int base;

    ////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] word_of(input logic [22:0] a);
        return a[15:0] ^ 16'h5A5A;
    endfunction
    // Array model answers in the same cycle
    assign array_data = word_of(array_addr);

    fbrp_core i_dut (
        .i_core_clk(clk),
        .i_reset(reset),
        .i_pins(pins),
        .i_address_lines(addr_lines),
        .o_array_addr(array_addr),
        .i_array_data(array_data),
        .o_data_lines(data_lines),
        .o_data_lines_oe(data_oe),
        .o_word_valid_flag(rdy),
        .o_word_valid_oe(rdy_oe),
        .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata),
        .i_reg_wr(reg_wr),
        .i_reg_rd(reg_rd),
        .o_reg_rdata(reg_rdata)
    );
    fbrp_host i_host (
        .i_data_lines(data_lines),
        .i_data_lines_oe(data_oe),
        .i_word_valid_flag(rdy),
        .i_word_valid_oe(rdy_oe),
        .o_pins(pins),
        .o_address_lines(addr_lines)
    );

    ////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, input logic [31:0] mask,
                            input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata & mask, exp);
    endtask
    // Burst and compare every valid word with its expected address
    task automatic run(input logic [22:0] a, input int sus, input bit w8);
        logic [22:0] e;
        i_host.burst(a, 14, sus);
        check(32'(i_host.words.size() >= 6), 32'h0000_0001);
        for (int i = 0; i < i_host.words.size(); i++) begin
            e = w8 ? {a[22:3], 3'(a[2:0] + 3'(i))} : a + 23'(i);
            check(32'(i_host.words[i]), 32'(word_of(e)));
        end
    endtask
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        reg_read(fbrp_pkg::REG_CFG, 32'h0000_03FF, 32'h0000_0002);
        reg_read(fbrp_pkg::REG_BANK, 32'hFFFF_FFFF, 32'h0000_0000);
        reg_read(fbrp_pkg::REG_STAT, 32'h0000_0007, 32'h0000_0000);
        reg_read(4'hC, 32'hFFFF_FFFF, 32'h0000_0000);
        $display("test reset done");
        i_host.async_read(23'h00_1234);
        check(32'(i_host.rd), 32'(word_of(23'h00_1234)));
        $display("test async read done");
        reg_write(fbrp_pkg::REG_CFG, 32'h0000_0102);
        reg_read(fbrp_pkg::REG_CFG, 32'h0000_03FF, 32'h0000_0102);
        reg_read(fbrp_pkg::REG_STAT, 32'h0000_0007, 32'h0000_0001);
        run(23'h00_003C, 99, 1'b0);
        check(32'(i_host.post_lows), 32'h0000_0002);
        reg_read(fbrp_pkg::REG_STAT, 32'h0000_0007, 32'h0000_0001);
        base = i_host.init_lows;
        run(23'h00_003E, 99, 1'b0);
        check(32'(i_host.post_lows), 32'h0000_0000);
        run(23'h00_003D, 99, 1'b0);
        check(32'(i_host.init_lows), 32'(base + 1));
        $display("test continuous burst done");
        run(23'h00_0100, 6, 1'b0);
        check(32'(i_host.pin_bad), 32'h0000_0000);
        $display("test suspend done");
        reg_write(fbrp_pkg::REG_CFG, 32'h0000_0112);
        run(23'h00_0039, 99, 1'b1);
        check(32'(i_host.post_lows), 32'h0000_0000);
        i_host.burst(23'h00_0038, 135, 999);
        check(32'(i_host.words.size()), 32'h0000_0080);
        check(32'(i_host.words[127]), 32'(word_of(23'h00_003F)));
        $display("test wrap done");
        reg_write(fbrp_pkg::REG_CFG, 32'h0000_0302);
        run(23'h00_003C, 99, 1'b0);
        base = i_host.init_lows;
        run(23'h00_003E, 99, 1'b0);
        check(32'(i_host.init_lows), 32'(base + 2));
        check(32'(i_host.post_lows), 32'h0000_0000);
        $display("test reduced variant done");
        reg_write(fbrp_pkg::REG_CFG, 32'h0000_0102);
        reg_write(fbrp_pkg::REG_BANK, 32'h0000_0002);
        i_host.burst(23'h07_FFFD, 14, 99);
        check(32'(i_host.last_data), 32'(fbrp_pkg::STATUS_WORD));
        check(32'(i_host.post_lows), 32'h0000_0007);
        // Chip enable high ended the halted burst; address kept
        reg_read(fbrp_pkg::REG_STAT, 32'h07FF_FFFF, 32'h0080_0001);
        $display("test busy bank done");
        i_host.clear();
        reg_read(fbrp_pkg::REG_CFG, 32'h0000_03FF, 32'h0000_0002);
        reg_read(fbrp_pkg::REG_BANK, 32'hFFFF_FFFF, 32'h0000_0000);
        $display("test clear done");
        test_done();
    end
endmodule
`default_nettype wire
